//--- logic/pfb_defines.svh
// Register offsets, field positions, reset values and frame counts for the frame timing block
`ifndef PFB_DEFINES_SVH
`define PFB_DEFINES_SVH

`define PFB_ADDR_W 3
`define PFB_DATA_W 8

`define PFB_OFF_CLOCKING 3'h0
`define PFB_OFF_CTRL0 3'h1
`define PFB_OFF_CTRL1 3'h2
`define PFB_OFF_CTRL2 3'h3
`define PFB_OFF_CTRL3 3'h4
`define PFB_OFF_POWER 3'h5
`define PFB_OFF_STATUS 3'h6

`define PFB_CLK_SEL_BIT 0
`define PFB_CLK_PRE_LSB 1
`define PFB_CLK_FRAME_DIVIDER_RATIO_LSB 4
`define PFB_C0_BLINK_DIVIDER_RATIO_LSB 0
`define PFB_C0_BLINK_MODE_FIELD_LSB 4
`define PFB_C1_CONTRAST_LSB 0
`define PFB_C1_PUMP_BIT 3
`define PFB_C1_BIASSEL_BIT 4
`define PFB_C1_HBD_LSB 5
`define PFB_C2_MODE_LSB 0
`define PFB_C2_DM_LSB 4
`define PFB_C3_WGEN_BIT 0
`define PFB_C3_PTYPE_BIT 1
`define PFB_C3_DIR_BIT 2
`define PFB_PWR_ON_BIT 0

`define PFB_RST_CLOCKING 8'h00
`define PFB_RST_CTRL0 8'h00
`define PFB_RST_CTRL1 8'h00
`define PFB_RST_CTRL2 8'h00
`define PFB_RST_CTRL3 8'h00
`define PFB_RST_POWER 8'h00

`define PFB_BASE_EVEN 5'h08
`define PFB_BASE_THIRD 5'h06

`define PFB_BM_NONE 2'h0
`define PFB_BM_ONE 2'h1
`define PFB_BM_SEGMENT_LINE_0 2'h2
`define PFB_BM_ALL 2'h3
`define PFB_DM_BANK_A 2'h0
`define PFB_DM_BANK_B 2'h1
`define PFB_DM_ALTERNATE 2'h2
`define PFB_DM_BLANK 2'h3

`endif

//--- logic/pfb_pkg.sv
// Types shared by the frame timing block
`default_nettype none
package pfb_pkg;
  typedef enum logic [3:0] {
    PFB_STATIC = 4'h1,
    PFB_HALF = 4'h2,
    PFB_THIRD = 4'h4,
    PFB_QUARTER = 4'h8
  } pfb_duty_t;
endpackage
`default_nettype wire

//--- logic/pfb_timing.sv
// Panel frame, blink, timer and bias supply control with a plain register port
`timescale 1ns/1ps
`default_nettype none
`include "pfb_defines.svh"

module pfb_timing
  import pfb_pkg::*;
#(
  parameter logic [7:0] PRE_LUT [0:7] = '{8'h01, 8'h02, 8'h04, 8'h08,
                                         8'h10, 8'h20, 8'h40, 8'h80},
  parameter logic [7:0] FRAME_DIVIDER_RATIO_LUT [0:15] = '{8'h02, 8'h04, 8'h06, 8'h08,
                                           8'h0a, 8'h0c, 8'h0e, 8'h10,
                                           8'h12, 8'h14, 8'h16, 8'h18,
                                           8'h1a, 8'h1c, 8'h1e, 8'h20},
  parameter logic [7:0] BLINK_DIVIDER_RATIO_LUT [0:7] = '{8'h01, 8'h02, 8'h03, 8'h04,
                                          8'h05, 8'h06, 8'h07, 8'h08}
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [`PFB_ADDR_W-1:0] addr,
  input wire logic [`PFB_DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [`PFB_DATA_W-1:0] rdata,
  input wire logic watchdog_oscillator,
  output logic frame_event,
  output logic blink_event,
  output logic [4:0] frame_phase,
  output logic frame_odd,
  output logic waveform_active,
  output logic high_drive,
  output logic bias_high_select,
  output logic bank_b_select,
  output logic blank_segment_line_0_common_line_0,
  output logic blank_segment_line_0,
  output logic blank_all,
  output logic pump_on,
  output logic pump_tripler,
  output logic pump_doubler,
  output logic pump_high_current,
  output logic bias_src_core,
  output logic bias_src_external,
  output logic panel_pin_to_bias,
  output logic [2:0] contrast_level
);

  // Software-written settings; copied into the active set at pattern end
  logic [7:0] sw_clocking;
  logic [7:0] sw_ctrl0;
  logic [7:0] sw_ctrl1;
  logic [7:0] sw_ctrl2;
  logic [7:0] sw_ctrl3;
  logic [7:0] sw_power;

  logic act_input_clock_source_select;
  logic [2:0] act_pre;
  logic [3:0] act_frame_divider_ratio;
  logic [2:0] act_blink_divider_ratio;
  logic [1:0] act_blink_mode_field;
  logic [2:0] act_contrast;
  logic act_charge_pump_enable;
  logic act_biassel;
  logic [2:0] act_hbd;
  logic [3:0] act_mode;
  logic [1:0] act_dm;
  logic act_wgen;
  logic act_ptype;
  logic act_dir;
  logic act_power;

  logic osc_prev;
  logic [7:0] pre_cnt;
  logic [7:0] frame_divider_ratio_cnt;
  logic [4:0] frame_cyc;
  logic [7:0] blink_cnt;
  logic blink_phase;
  logic [3:0] hd_cnt;

  pfb_duty_t duty;
  logic type_b;
  logic [4:0] base_len;
  logic [4:0] dead;
  logic [4:0] frame_len;
  logic [7:0] pre_ratio;
  logic [7:0] frame_divider_ratio_ratio;
  logic [7:0] blink_half;
  logic run;
  logic src_tick;
  logic pre_tick;
  logic fclk_tick;
  logic frame_end;
  logic pattern_end;
  logic load;
  logic blink_toggle;
  logic blink_off;

  // Register port
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sw_clocking <= `PFB_RST_CLOCKING;
      sw_ctrl0 <= `PFB_RST_CTRL0;
      sw_ctrl1 <= `PFB_RST_CTRL1;
      sw_ctrl2 <= `PFB_RST_CTRL2;
      sw_ctrl3 <= `PFB_RST_CTRL3;
      sw_power <= `PFB_RST_POWER;
    end else if (wr) begin
      unique case (addr)
        `PFB_OFF_CLOCKING: sw_clocking <= wdata;
        `PFB_OFF_CTRL0: sw_ctrl0 <= wdata;
        `PFB_OFF_CTRL1: sw_ctrl1 <= wdata;
        `PFB_OFF_CTRL2: sw_ctrl2 <= wdata;
        `PFB_OFF_CTRL3: sw_ctrl3 <= wdata;
        `PFB_OFF_POWER: sw_power <= wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        `PFB_OFF_CLOCKING: rdata <= sw_clocking;
        `PFB_OFF_CTRL0: rdata <= sw_ctrl0;
        `PFB_OFF_CTRL1: rdata <= sw_ctrl1;
        `PFB_OFF_CTRL2: rdata <= sw_ctrl2;
        `PFB_OFF_CTRL3: rdata <= sw_ctrl3;
        `PFB_OFF_POWER: rdata <= sw_power;
        `PFB_OFF_STATUS: rdata <= {frame_cyc[3:0], act_power, frame_odd, blink_phase,
                                   bank_b_select};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // While unpowered the active set follows software at once, so power-up needs no frame
  assign load = !act_power || pattern_end;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      act_input_clock_source_select <= 1'b0;
      act_pre <= 3'h0;
      act_frame_divider_ratio <= 4'h0;
      act_blink_divider_ratio <= 3'h0;
      act_blink_mode_field <= 2'h0;
      act_contrast <= 3'h0;
      act_charge_pump_enable <= 1'b0;
      act_biassel <= 1'b0;
      act_hbd <= 3'h0;
      act_mode <= 4'h0;
      act_dm <= 2'h0;
      act_wgen <= 1'b0;
      act_ptype <= 1'b0;
      act_dir <= 1'b0;
      act_power <= 1'b0;
    end else if (load) begin
      act_input_clock_source_select <= sw_clocking[`PFB_CLK_SEL_BIT];
      act_pre <= sw_clocking[`PFB_CLK_PRE_LSB +: 3];
      act_frame_divider_ratio <= sw_clocking[`PFB_CLK_FRAME_DIVIDER_RATIO_LSB +: 4];
      act_blink_divider_ratio <= sw_ctrl0[`PFB_C0_BLINK_DIVIDER_RATIO_LSB +: 3];
      act_blink_mode_field <= sw_ctrl0[`PFB_C0_BLINK_MODE_FIELD_LSB +: 2];
      act_contrast <= sw_ctrl1[`PFB_C1_CONTRAST_LSB +: 3];
      act_charge_pump_enable <= sw_ctrl1[`PFB_C1_PUMP_BIT];
      act_biassel <= sw_ctrl1[`PFB_C1_BIASSEL_BIT];
      act_hbd <= sw_ctrl1[`PFB_C1_HBD_LSB +: 3];
      act_mode <= sw_ctrl2[`PFB_C2_MODE_LSB +: 4];
      act_dm <= sw_ctrl2[`PFB_C2_DM_LSB +: 2];
      act_wgen <= sw_ctrl3[`PFB_C3_WGEN_BIT];
      act_ptype <= sw_ctrl3[`PFB_C3_PTYPE_BIT];
      act_dir <= sw_ctrl3[`PFB_C3_DIR_BIT];
      act_power <= sw_power[`PFB_PWR_ON_BIT];
    end
  end

  // Mode decode; reserved codes run as static so the dividers stay sane
  always_comb begin
    if (act_mode == 4'h0 || act_mode > 4'hc) begin
      duty = PFB_STATIC;
    end else if (act_mode <= 4'h4) begin
      duty = PFB_HALF;
    end else if (act_mode <= 4'h8) begin
      duty = PFB_THIRD;
    end else begin
      duty = PFB_QUARTER;
    end
  end

  assign type_b = (duty != PFB_STATIC) && !act_mode[0];
  assign base_len = (duty == PFB_THIRD) ? `PFB_BASE_THIRD : `PFB_BASE_EVEN;
  // Pump-generated panel voltage sets contrast itself, so no dead cycles then
  assign dead = act_charge_pump_enable ? 5'h00 : {2'b00, act_contrast};
  assign frame_len = (!type_b || frame_odd) ? 5'(base_len + dead) : base_len;

  assign pre_ratio = PRE_LUT[act_pre];
  assign frame_divider_ratio_ratio = FRAME_DIVIDER_RATIO_LUT[act_frame_divider_ratio];
  assign blink_half = 8'(BLINK_DIVIDER_RATIO_LUT[act_blink_divider_ratio] << 1);

  // Timer runs on power alone; waveform enable only gates the drive
  assign run = act_power;
  // Oscillator input is taken as synchronous; its rising edge is one tick
  assign src_tick = act_input_clock_source_select ? (watchdog_oscillator && !osc_prev) : 1'b1;
  assign pre_tick = run && src_tick && (pre_cnt == 8'(pre_ratio - 8'h01));
  assign fclk_tick = pre_tick && (frame_divider_ratio_cnt == 8'(frame_divider_ratio_ratio - 8'h01));
  assign frame_end = fclk_tick && (frame_cyc == 5'(frame_len - 5'h01));
  assign pattern_end = frame_end && (!type_b || frame_odd);
  assign blink_toggle = frame_end && (blink_cnt >= 8'(blink_half - 8'h01));

  always_ff @(posedge clock) begin
    if (!nrst) begin
      osc_prev <= 1'b0;
    end else begin
      osc_prev <= watchdog_oscillator;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst || !run) begin
      pre_cnt <= 8'h00;
    end else if (src_tick) begin
      pre_cnt <= pre_tick ? 8'h00 : 8'(pre_cnt + 8'h01);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst || !run) begin
      frame_divider_ratio_cnt <= 8'h00;
    end else if (pre_tick) begin
      frame_divider_ratio_cnt <= fclk_tick ? 8'h00 : 8'(frame_divider_ratio_cnt + 8'h01);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst || !run) begin
      frame_cyc <= 5'h00;
      frame_odd <= 1'b0;
    end else if (fclk_tick) begin
      frame_cyc <= frame_end ? 5'h00 : 5'(frame_cyc + 5'h01);
      if (frame_end) begin
        frame_odd <= type_b ? !frame_odd : 1'b0;
      end
    end
  end

  // Blink phase flips every 2*ratio frames, giving one full blink per 4*ratio frames
  always_ff @(posedge clock) begin
    if (!nrst || !run) begin
      blink_cnt <= 8'h00;
      blink_phase <= 1'b0;
    end else if (frame_end) begin
      blink_cnt <= blink_toggle ? 8'h00 : 8'(blink_cnt + 8'h01);
      if (blink_toggle) begin
        blink_phase <= !blink_phase;
      end
    end
  end

  // Outside static duty, raised drive starts at every frame clock edge and lasts duration+1 prescaler ticks
  always_ff @(posedge clock) begin
    if (!nrst || !run || !act_wgen || duty == PFB_STATIC) begin
      hd_cnt <= 4'h0;
    end else if (fclk_tick) begin
      hd_cnt <= 4'({1'b0, act_hbd} + 4'h1);
    end else if (pre_tick && hd_cnt != 4'h0) begin
      hd_cnt <= 4'(hd_cnt - 4'h1);
    end
  end

  assign blink_off = blink_phase && act_dm[1] == 1'b0 && act_blink_mode_field != `PFB_BM_NONE;

  // Timing outputs
  always_ff @(posedge clock) begin
    if (!nrst) begin
      frame_event <= 1'b0;
      blink_event <= 1'b0;
      frame_phase <= 5'h00;
      waveform_active <= 1'b0;
      high_drive <= 1'b0;
      bias_high_select <= 1'b0;
      contrast_level <= 3'h0;
    end else begin
      frame_event <= frame_end;
      blink_event <= blink_toggle && !blink_phase;
      frame_phase <= frame_cyc;
      waveform_active <= run && act_wgen;
      high_drive <= (hd_cnt != 4'h0);
      bias_high_select <= act_biassel;
      contrast_level <= act_contrast;
    end
  end

  // Bank, blink and blank outputs
  always_ff @(posedge clock) begin
    if (!nrst) begin
      bank_b_select <= 1'b0;
      blank_segment_line_0_common_line_0 <= 1'b0;
      blank_segment_line_0 <= 1'b0;
      blank_all <= 1'b0;
    end else begin
      bank_b_select <= (act_dm == `PFB_DM_ALTERNATE) ? blink_phase : act_dm[0];
      blank_segment_line_0_common_line_0 <= blink_off && act_blink_mode_field == `PFB_BM_ONE;
      blank_segment_line_0 <= blink_off && act_blink_mode_field == `PFB_BM_SEGMENT_LINE_0;
      blank_all <= (run && act_dm == `PFB_DM_BLANK) ||
                   (blink_off && act_blink_mode_field == `PFB_BM_ALL);
    end
  end

  // Supply routing
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pump_on <= 1'b0;
      pump_tripler <= 1'b0;
      pump_doubler <= 1'b0;
      pump_high_current <= 1'b0;
      bias_src_core <= 1'b0;
      bias_src_external <= 1'b0;
      panel_pin_to_bias <= 1'b0;
    end else begin
      pump_on <= act_power && act_dir && act_charge_pump_enable;
      pump_tripler <= act_power && act_dir && act_charge_pump_enable && !act_ptype;
      pump_doubler <= act_power && act_dir && act_charge_pump_enable && act_ptype;
      pump_high_current <= act_power && act_dir && act_charge_pump_enable && act_biassel;
      bias_src_core <= act_power && act_dir && !act_charge_pump_enable;
      bias_src_external <= act_power && !act_dir && !act_charge_pump_enable;
      panel_pin_to_bias <= act_power && (act_charge_pump_enable || !act_dir);
    end
  end

  a_peripheral_source: assert property (@(posedge clock) disable iff (!nrst)
    run && !act_input_clock_source_select && !pre_tick |=> pre_cnt == 8'($past(pre_cnt) + 8'h01))
    else $error("prescaler missed a peripheral tick");

  a_oscillator_source: assert property (@(posedge clock) disable iff (!nrst)
    run && act_input_clock_source_select && !(watchdog_oscillator && !osc_prev) |=> $stable(pre_cnt))
    else $error("prescaler moved without oscillator edge");

  a_ratio_field_a_ratio: assert property (@(posedge clock) disable iff (!nrst)
    pre_tick |-> pre_cnt == 8'(pre_ratio - 8'h01) && src_tick)
    else $error("prescaler tick off ratio");

  a_frame_from_pre: assert property (@(posedge clock) disable iff (!nrst)
    fclk_tick |-> pre_tick && frame_divider_ratio_cnt == 8'(frame_divider_ratio_ratio - 8'h01))
    else $error("frame clock not on prescaler tick");

  a_frame_length: assert property (@(posedge clock) disable iff (!nrst)
    frame_end |-> frame_cyc + 5'h01 >= base_len && frame_cyc + 5'h01 <= base_len + 5'h07)
    else $error("frame length out of range");

  a_dead_pair: assert property (@(posedge clock) disable iff (!nrst)
    frame_end && type_b && !frame_odd |-> frame_cyc == 5'(base_len - 5'h01))
    else $error("dead cycles in first frame of pair");

  a_pattern_pair: assert property (@(posedge clock) disable iff (!nrst)
    pattern_end && type_b |-> frame_odd) else $error("type B pattern ended early");

  a_settings_hold: assert property (@(posedge clock) disable iff (!nrst)
    act_power && !pattern_end |=> $stable(act_mode) && $stable(act_contrast))
    else $error("settings changed mid pattern");

  a_bank_alternate: assert property (@(posedge clock) disable iff (!nrst)
    act_dm == `PFB_DM_ALTERNATE && !load |=> bank_b_select == $past(blink_phase))
    else $error("bank not following blink");

  a_blank_all: assert property (@(posedge clock) disable iff (!nrst)
    run && act_dm == `PFB_DM_BLANK |=> blank_all && !blank_segment_line_0 && !blank_segment_line_0_common_line_0)
    else $error("blanking not applied");

  a_power_off: assert property (@(posedge clock) disable iff (!nrst)
    !act_power |=> !pump_on && !panel_pin_to_bias && !bias_src_core && !bias_src_external)
    else $error("supply active while off");

  a_pump_type: assert property (@(posedge clock) disable iff (!nrst)
    pump_on |-> pump_tripler != pump_doubler) else $error("pump type not exclusive");

endmodule // pfb_timing
`default_nettype wire

//--- tb/pfb_glass_model.sv
// Slow oscillator beside the panel, used as the alternate input clock source
`timescale 1ns/1ps
`default_nettype none

module pfb_glass_model #(
  parameter int TICK_HALF = 2
) (
  input wire logic clock,
  output logic watchdog_oscillator
);
  int cnt = 0;
  logic osc = 1'b0;

  assign watchdog_oscillator = osc;

  // Free running: the oscillator does not stop between frames
  always @(posedge clock) begin
    cnt <= (cnt == TICK_HALF - 1) ? 0 : cnt + 1;
    if (cnt == TICK_HALF - 1) begin
      osc <= ~osc;
    end
  end
endmodule // pfb_glass_model

`default_nettype wire

//--- tb/pfb_timing_tb.sv
// Self-checking bench for the panel frame, blink and bias control block
`timescale 1ns/1ps
`default_nettype none
`include "pfb_defines.svh"

module pfb_timing_tb
  import pfb_pkg::*;
;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic wdo;
  logic frame_event, blink_event, waveform_active, bias_high_select, bank_b_select;
  logic blank_segment_line_0_common_line_0, blank_segment_line_0, blank_all;
  logic pump_on, pump_tripler, pump_doubler, bias_src_core, bias_src_external, panel_pin_to_bias;
  logic [4:0] frame_phase;
  logic frame_odd, high_drive, pump_high_current;
  logic [2:0] contrast_level;
  int compares = 0;
  int miscompares = 0;
  int cycles = 0;
  int a, b, i, j;
  logic [7:0] d, seen, e;
  logic ev, pw, dir, pump, pt;
  // Clocking 8'h02 is ratio_field_a 2, frame divide 2; 8'h94 is divide by 4 and 20
  logic [7:0] t_clk [0:6] = '{8'h02, 8'h94, 8'h02, 8'h02, 8'h02, 8'h02, 8'h03};
  logic [7:0] t_c1 [0:6] = '{8'h02, 8'h02, 8'h02, 8'h00, 8'h0a, 8'h02, 8'h00};
  logic [7:0] t_c2 [0:6] = '{8'h09, 8'h09, 8'h05, 8'h00, 8'h09, 8'h0a, 8'h09};
  int t_len [0:6] = '{80, 1600, 64, 64, 64, 72, 256};
  logic [7:0] m_exp [0:5] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h14};

  always #50 clock = ~clock;

  pfb_glass_model glass (.clock(clock), .watchdog_oscillator(wdo));

  pfb_timing dut (
    .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .watchdog_oscillator(wdo), .frame_event(frame_event),
    .blink_event(blink_event), .frame_phase(frame_phase), .frame_odd(frame_odd),
    .waveform_active(waveform_active), .high_drive(high_drive),
    .bias_high_select(bias_high_select),
    .bank_b_select(bank_b_select), .blank_segment_line_0_common_line_0(blank_segment_line_0_common_line_0),
    .blank_segment_line_0(blank_segment_line_0), .blank_all(blank_all), .pump_on(pump_on),
    .pump_tripler(pump_tripler), .pump_doubler(pump_doubler),
    .pump_high_current(pump_high_current),
    .bias_src_core(bias_src_core), .bias_src_external(bias_src_external),
    .panel_pin_to_bias(panel_pin_to_bias), .contrast_level(contrast_level)
  );

  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    compares++;
    if (got != exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [2:0] ad, input logic [7:0] dt);
    @(posedge clock);
    addr <= ad;
    wdata <= dt;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] ad, output logic [7:0] dt);
    @(posedge clock);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    dt = rdata;
  endtask

  // Cycles until the next event pulse; bounded so a dead divider cannot hang
  task automatic wait_ev(input bit blink, output int n);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (((blink ? blink_event : frame_event) !== 1'b1) && n < 5000);
  endtask

  task automatic cfg(input logic [7:0] ck, c0, c1, c2, c3, p);
    wr_reg(`PFB_OFF_CLOCKING, ck);
    wr_reg(`PFB_OFF_CTRL0, c0);
    wr_reg(`PFB_OFF_CTRL1, c1);
    wr_reg(`PFB_OFF_CTRL2, c2);
    wr_reg(`PFB_OFF_CTRL3, c3);
    wr_reg(`PFB_OFF_POWER, p);
  endtask

  // Three frames cover a whole Type B pattern plus the frame in progress
  task automatic settle();
    repeat (3) wait_ev(1'b0, a);
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
  end

  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    for (i = 0; i < 8; i++) begin
      if (i != 6) begin
        rd_reg(i[2:0], d);
        chk_reg(d, 8'h00);
      end
    end
    @(posedge clock);
    #1;
    chk_reg(rdata, 8'h00);
    wr_reg(`PFB_OFF_CTRL1, 8'h37);
    rd_reg(`PFB_OFF_CTRL1, d);
    chk_reg(d, 8'h37);
    for (i = 0; i < 7; i++) begin
      cfg(t_clk[i], 8'h00, t_c1[i], t_c2[i], 8'h01, 8'h01);
      settle();
      wait_ev(1'b0, a);
      wait_ev(1'b0, b);
      chk_cnt(a + b, t_len[i]);
    end
    // A contrast change lands only after the frame in progress
    cfg(8'h02, 8'h00, 8'h00, 8'h09, 8'h01, 8'h01);
    settle();
    wr_reg(`PFB_OFF_CTRL1, 8'h07);
    wait_ev(1'b0, a);
    wait_ev(1'b0, b);
    chk_cnt(a + 2, 32);
    chk_cnt(b, 60);
    chk_reg({3'h0, frame_phase}, 8'h0e);
    chk_reg({5'h0, contrast_level}, 8'h07);
    for (i = 0; i < 2; i++) begin
      cfg(8'h02, 8'h30 | i[7:0], 8'h00, 8'h00, 8'h01, 8'h01);
      settle();
      wait_ev(1'b1, a);
      wait_ev(1'b1, b);
      chk_cnt(b, 128 * (i + 1));
    end
    for (j = 0; j < 6; j++) begin
      cfg(8'h02, (j < 4) ? j[7:0] << 4 : 8'h30, 8'h00, (j < 4) ? 8'h00 : 8'h20 + 8'h10 * (j - 4),
          8'h01, 8'h01);
      settle();
      seen = 8'h10;
      repeat (300) begin
        @(posedge clock);
        #1;
        seen = seen | {4'h0, bank_b_select, blank_all, blank_segment_line_0, blank_segment_line_0_common_line_0};
        if (blank_all !== 1'b1) seen[4] = 1'b0;
      end
      e = (j == 5) ? 8'h14 : 8'hff;
      chk_reg(seen & e, m_exp[j]);
    end
    cfg(8'h02, 8'h00, 8'h02, 8'h1a, 8'h01, 8'h01);
    settle();
    wr_reg(`PFB_OFF_STATUS, 8'h00);
    rd_reg(`PFB_OFF_STATUS, d);
    chk_reg(d & 8'h09, 8'h09);
    chk_reg({7'h0, bank_b_select}, 8'h01);
    // Type B pair: only the second frame carries the dead cycles
    wait_ev(1'b0, a);
    pt = frame_odd;
    wait_ev(1'b0, b);
    chk_cnt(b, pt ? 40 : 32);
    chk_reg({7'h0, frame_odd}, {7'h0, ~pt});
    for (i = 0; i < 16; i++) begin
      pump = i[0];
      dir = i[1];
      pw = i[2];
      pt = i[3];
      cfg(8'h02, 8'h00, {3'h0, pump, pump, 3'h0}, 8'h01, {5'h0, dir, pt, pt}, {7'h0, pw});
      repeat (150) @(posedge clock);
      ev = 1'b0;
      b = 0;
      repeat (100) begin
        @(posedge clock);
        #1;
        ev = ev | (frame_event === 1'b1);
        b = b + ((high_drive === 1'b1) ? 1 : 0);
      end
      chk_cnt(b, (pw & pt) ? 50 : 0);
      e = {pw & pt, pw & dir & pump & ~pt, pw & dir & pump & pt, pw & dir & pump,
           pw & dir & ~pump, pw & ~dir & ~pump, pw & (pump | ~dir), pw};
      chk_reg({waveform_active, pump_tripler, pump_doubler, pump_on, bias_src_core,
               bias_src_external, panel_pin_to_bias, ev}, e);
      chk_reg({6'h0, pump_high_current, bias_high_select}, {6'h0, pw & dir & pump, pump});
    end
    report_and_stop();
  end
endmodule // pfb_timing_tb

`default_nettype wire
